// ==== rtl/fdh_defines.svh ====
// Constants of the disk controller host port, with the overview of operation.
// Overview of operation
// - Slave processor deposits status and disk read data into the shared buffer.
// - Controller timing comes from a local clock unrelated to the host clock.
// - Drive control outputs sit in addressable latches written only by the slave.
// - Slave runs its routines from a 4K by 8 program ROM on internal buses.
// - A 1K byte buffer of two 1K by 4 memories is shared by both sides.
// - One memory holds the upper nibble of each byte, the other the lower.
// - An 8-bit transceiver couples host data lines to internal bus only during host accesses.
// - Slave addresses 8K over 13 lines; a 2-to-1 mux picks buffer address source.
// - Internal address selects latch bits; two 2-to-4 decoders make the selects.
// - Under lockout the mux keeps slave address and the transceiver is disabled.
// - Acknowledge only when lockout is low and the grant flop shows a granted access.
// - A host access during lockout never receives an acknowledge.
// - Acknowledge driver is enabled only while the grant flop is in granted (low) state and lockout is low.
// - A local state counter sequences host access slots and internal cycles.
// - After acknowledge, sequencing halts until host drops address strobe.
// - Host lockout is one bit of the slave's general drive control latch.
`ifndef FDH_DEFINES_SVH
`define FDH_DEFINES_SVH
`define FDH_SLAVE_AW      13
`define FDH_BUF_AW        10
`define FDH_ROM_AW        12
`define FDH_SEQ_LOAD_HOST 4'h8
`define FDH_SEQ_LOAD_INT  4'h9
`define FDH_SEQ_SAMPLE    4'h9
`define FDH_SEQ_ACK       4'hA
`define FDH_SEQ_PHI       4'hC
`define FDH_LATCH_SEL     2'h3
`define FDH_LOCKOUT_BIT   3'h2
`define FDH_SEL_ROM       2'h1
`define FDH_SEL_BUF       2'h0
`define FDH_SEL_IO        2'h2
`endif

// ==== rtl/fdh_host_port.sv ====
// Shared buffer host port of the floppy controller with lockout and acknowledge sequencing.
`include "fdh_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module fdh_host_port
  import fdh_pkg::*;
#(
  parameter int SLAVE_AW = `FDH_SLAVE_AW,
  parameter int BUF_AW   = `FDH_BUF_AW
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  // Host bus
  input  wire logic                host_sel,
  input  wire logic                host_addr_strobe,
  input  wire logic                host_rd,
  input  wire logic [BUF_AW-1:0]   host_addr,
  input  wire logic [7:0]          host_data_lines_in,
  output logic [7:0]               host_data_lines_out,
  output logic                     host_data_lines_oe,
  output logic                     transfer_ack_n_out,
  output logic                     transfer_ack_n_oe,
  // Slave processor bus
  input  wire logic [SLAVE_AW-1:0] slave_addr_lines,
  input  wire logic                slave_wr,
  input  wire logic                slave_rd,
  input  wire logic [7:0]          slave_data_out,
  output logic [7:0]               slave_data_in,
  output logic                     slave_phi,
  // ROM port
  output logic [`FDH_ROM_AW-1:0]   rom_addr,
  input  wire logic [7:0]          rom_data,
  // Drive and status latches
  output logic [7:0]               drive_latch,
  output logic [7:0]               general_latch,
  output logic                     host_lockout
);
  logic [3:0]       seq_reg;
  logic             req_s1_reg;
  logic             req_s2_reg;
  logic             grant_n_reg;
  fdh_acc_t         acc_reg;
  logic [3:0]       nib_hi [0:(1<<BUF_AW)-1];
  logic [3:0]       nib_lo [0:(1<<BUF_AW)-1];
  logic [BUF_AW-1:0] buf_addr;
  logic             host_cycle;
  logic [3:0]       dec_main;
  logic [3:0]       dec_io;
  logic [7:0]       drive_q;
  logic [7:0]       general_q;
  logic             held;
  logic             lockout;
  logic [7:0]       buf_rd;

  assign lockout = general_q[`FDH_LOCKOUT_BIT];
  // Host request crosses two flops; only the second one is used below.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
    end else begin
      req_s1_reg <= host_sel & host_addr_strobe;
      req_s2_reg <= req_s1_reg;
    end
  end

  // Counter halts while acknowledge waits for the strobe to drop.
  assign held = (acc_reg == FDH_ACC_ACK) && req_s2_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= `FDH_SEQ_LOAD_INT;
    end else if (!held) begin
      if (seq_reg == 4'hF) begin
        seq_reg <= grant_n_reg ? `FDH_SEQ_LOAD_INT : `FDH_SEQ_LOAD_HOST;
      end else begin
        seq_reg <= seq_reg + 4'h1;
      end
    end
  end

  // Grant flop is low while a host access owns the buffer.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_n_reg <= 1'b1;
    end else if (lockout) begin
      grant_n_reg <= 1'b1;
    end else if (!req_s2_reg) begin
      grant_n_reg <= 1'b1;
    end else if (seq_reg == `FDH_SEQ_SAMPLE) begin
      grant_n_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_reg <= FDH_ACC_IDLE;
    end else begin
      case (acc_reg)
        FDH_ACC_IDLE: if (!grant_n_reg && !lockout) acc_reg <= FDH_ACC_WAIT;
        FDH_ACC_WAIT: begin
          if (lockout || grant_n_reg) begin
            acc_reg <= FDH_ACC_IDLE;
          end else if (seq_reg == `FDH_SEQ_ACK) begin
            acc_reg <= FDH_ACC_ACK;
          end
        end
        FDH_ACC_ACK: if (!req_s2_reg) acc_reg <= FDH_ACC_IDLE;
        default: acc_reg <= FDH_ACC_IDLE;
      endcase
    end
  end

  assign host_cycle = !grant_n_reg && !lockout;
  assign buf_addr = host_cycle ? host_addr : slave_addr_lines[BUF_AW-1:0];
  // Decoders: top two lines pick the region, two more pick the latch within I/O space.
  assign dec_main = 4'h1 << slave_addr_lines[SLAVE_AW-1 -: 2];
  assign dec_io = dec_main[`FDH_SEL_IO] ? (4'h1 << slave_addr_lines[5:4]) : 4'h0;

  // Both sides share one buffer; upper and lower nibbles in separate arrays.
  always_ff @(posedge sys_clk) begin
    if (host_cycle && !host_rd && acc_reg == FDH_ACC_WAIT) begin
      nib_hi[buf_addr] <= host_data_lines_in[7:4];
      nib_lo[buf_addr] <= host_data_lines_in[3:0];
    end else if (!host_cycle && slave_wr && dec_main[`FDH_SEL_BUF]) begin
      nib_hi[buf_addr] <= slave_data_out[7:4];
      nib_lo[buf_addr] <= slave_data_out[3:0];
    end
  end
  assign buf_rd = {nib_hi[buf_addr], nib_lo[buf_addr]};

  fdh_latch8 u_drive (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (slave_wr && dec_io[0]),
    .bit_sel (slave_addr_lines[2:0]),
    .bit_val (slave_addr_lines[3]),
    .q       (drive_q)
  );
  fdh_latch8 u_general (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (slave_wr && dec_io[1]),
    .bit_sel (slave_addr_lines[2:0]),
    .bit_val (slave_addr_lines[3]),
    .q       (general_q)
  );

  // Outputs are registered; the data read path lags one cycle behind the address.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_data_lines_out <= 8'h00;
      host_data_lines_oe  <= 1'b0;
      transfer_ack_n_out  <= 1'b1;
      transfer_ack_n_oe   <= 1'b0;
      slave_data_in       <= 8'h00;
      slave_phi           <= 1'b0;
      rom_addr            <= 12'h000;
      drive_latch         <= 8'h00;
      general_latch       <= 8'h00;
      host_lockout        <= 1'b0;
    end else begin
      host_data_lines_out <= buf_rd;
      host_data_lines_oe  <= host_cycle && host_rd;
      transfer_ack_n_out  <= !(acc_reg == FDH_ACC_ACK && !lockout);
      transfer_ack_n_oe   <= !grant_n_reg && !lockout;
      // Read data only moves on slave reads, so a write never disturbs what was fetched.
      slave_data_in       <= slave_rd ? (dec_main[`FDH_SEL_ROM] ? rom_data : buf_rd) : slave_data_in;
      slave_phi           <= seq_reg >= `FDH_SEQ_PHI;
      rom_addr            <= slave_addr_lines[`FDH_ROM_AW-1:0];
      drive_latch         <= drive_q;
      general_latch       <= general_q;
      host_lockout        <= lockout;
    end
  end

  property p_lock_no_ack;
    @(posedge sys_clk) disable iff (!reset_n) lockout |=> transfer_ack_n_out;
  endproperty
  a_lock_no_ack: assert property (p_lock_no_ack) else $error("ack under lockout");
  property p_lock_no_data;
    @(posedge sys_clk) disable iff (!reset_n) lockout |=> !host_data_lines_oe;
  endproperty
  a_lock_no_data: assert property (p_lock_no_data) else $error("data driven under lockout");
  property p_ack_cause;
    @(posedge sys_clk) disable iff (!reset_n) $fell(transfer_ack_n_out) |-> $past(!grant_n_reg);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without grant");
  property p_ack_oe;
    @(posedge sys_clk) disable iff (!reset_n) !transfer_ack_n_out |-> transfer_ack_n_oe;
  endproperty
  a_ack_oe: assert property (p_ack_oe) else $error("ack not driven");
  property p_hold;
    @(posedge sys_clk) disable iff (!reset_n) held |=> $stable(seq_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("sequence moved while held");
  property p_release;
    @(posedge sys_clk) disable iff (!reset_n) (acc_reg == FDH_ACC_ACK && !req_s2_reg) |=> ##1 transfer_ack_n_out;
  endproperty
  a_release: assert property (p_release) else $error("ack stuck after strobe drop");
  property p_sync;
    @(posedge sys_clk) disable iff (!reset_n) $rose(req_s2_reg) |-> $past(host_sel && host_addr_strobe, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser skipped");
  property p_lockout_out;
    @(posedge sys_clk) disable iff (!reset_n) lockout |=> host_lockout;
  endproperty
  a_lockout_out: assert property (p_lockout_out) else $error("lockout output lags");
endmodule
`default_nettype wire

// ==== rtl/fdh_latch8.sv ====
// Eight-bit addressable latch written one bit at a time.
`timescale 1ns/1ns
`default_nettype none
module fdh_latch8 (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Bit write
  input  wire logic       wr_en,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_val,
  // Latched bits
  output logic [7:0]      q
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          q[i] <= 1'b0;
        end else if (wr_en && bit_sel == 3'(i)) begin
          q[i] <= bit_val;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== rtl/fdh_pkg.sv ====
// Types of the disk controller host port.
package fdh_pkg;
  typedef enum logic [2:0] {
    FDH_ACC_IDLE = 3'b001,
    FDH_ACC_WAIT = 3'b010,
    FDH_ACC_ACK  = 3'b100
  } fdh_acc_t;
endpackage

// ==== verif/disk_ctrl_shared_ram_host_port_tb_top.sv ====
// Testbench of the disk controller host port against a behavioural buffer and latch model.
`timescale 1ns/1ns
`default_nettype none
module disk_ctrl_shared_ram_host_port_tb_top;
  logic        sys_clk, reset_n, host_sel, host_addr_strobe, host_rd, bus_error_n;
  logic        hd_oe, ack_out, ack_oe, slave_wr, slave_rd, slave_phi, host_lockout, acked;
  logic [9:0]  host_addr, a;
  logic [7:0]  hd_in, hd_out, sd_out, sd_in, rom_data, drive_latch, general_latch, d, q;
  logic [12:0] slave_addr;
  logic [11:0] rom_addr;
  logic [31:0] rng;
  logic [7:0]  exp_drive;
  int          num_errors, compares;
  int          phi_cnt;
  // Behavioural copy of the shared buffer, one integer per byte.
  int          buf_model [0:1023];
  assign rom_data = rom_addr[7:0] ^ 8'h5A;
  fdh_host_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .host_sel(host_sel),
    .host_addr_strobe(host_addr_strobe), .host_rd(host_rd), .host_addr(host_addr),
    .host_data_lines_in(hd_in), .host_data_lines_out(hd_out), .host_data_lines_oe(hd_oe),
    .transfer_ack_n_out(ack_out), .transfer_ack_n_oe(ack_oe), .slave_addr_lines(slave_addr),
    .slave_wr(slave_wr), .slave_rd(slave_rd), .slave_data_out(sd_out), .slave_data_in(sd_in),
    .slave_phi(slave_phi), .rom_addr(rom_addr), .rom_data(rom_data), .drive_latch(drive_latch),
    .general_latch(general_latch), .host_lockout(host_lockout));
  fdh_host_cpu_model cpu (.sys_clk(sys_clk), .host_sel(host_sel), .host_addr_strobe(host_addr_strobe),
    .host_rd(host_rd), .host_addr(host_addr), .host_data_lines_in(hd_in), .host_data_lines_out(hd_out),
    .host_data_lines_oe(hd_oe), .transfer_ack_n_out(ack_out), .transfer_ack_n_oe(ack_oe),
    .bus_error_n(bus_error_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic slave_cyc(input logic wr, input logic [12:0] sa, input logic [7:0] sd);
    @(posedge sys_clk);
    slave_addr <= sa;
    slave_wr <= wr;
    slave_rd <= !wr;
    sd_out <= sd;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    q = sd_in;
    @(posedge sys_clk);
    slave_wr <= 1'b0;
    slave_rd <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    reset_n = 1'b0;
    slave_addr = 13'h0000;
    slave_wr = 1'b0;
    slave_rd = 1'b0;
    sd_out = 8'h00;
    rng = 32'h600361FD;
    exp_drive = 8'h00;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check("ack_oe_reset", 8'h00, {7'h00, ack_oe});
    check("data_oe_reset", 8'h00, {7'h00, hd_oe});
    // With no host traffic the counter laps states 9 to 15, high in 12 to 15.
    phi_cnt = 0;
    repeat (28) begin
      @(negedge sys_clk);
      if (slave_phi) phi_cnt++;
    end
    check("phi_duty", 8'd16, 8'(phi_cnt));
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      a = rng[9:0];
      d = rng[17:10];
      slave_cyc(1'b1, {3'b000, a}, d);
      buf_model[a] = {24'h000000, d};
      cpu.access(1'b1, a, 8'h00, i, q, acked);
      check("host_read", 8'(buf_model[a]), q);
      check("read_acked", 8'h01, {7'h00, acked});
      check("ack_released", 8'h00, {7'h00, ack_oe});
      cpu.access(1'b0, a, ~d, 0, q, acked);
      check("write_acked", 8'h01, {7'h00, acked});
      buf_model[a] = {24'h000000, ~d};
      slave_cyc(1'b0, {3'b000, a}, 8'h00);
      check("slave_read", 8'(buf_model[a]), q);
    end
    $display("Buffer test done");
    slave_cyc(1'b0, 13'h0A37, 8'h00);
    check("rom_read", 8'h37 ^ 8'h5A, q);
    for (int b = 0; b < 8; b += 3) begin
      slave_cyc(1'b1, {2'b10, 5'h00, 2'b00, 1'b1, b[2:0]}, 8'h00);
      exp_drive[b] = 1'b1;
      check("drive_latch", exp_drive, drive_latch);
    end
    $display("Latch test done");
    slave_cyc(1'b1, {2'b10, 5'h00, 2'b01, 1'b1, 3'd2}, 8'h00);
    check("lockout_set", 8'h01, {7'h00, host_lockout});
    check("general_set", 8'h04, general_latch);
    cpu.access(1'b0, a, 8'hC3, 0, q, acked);
    check("locked_acked", 8'h00, {7'h00, acked});
    check("data_oe_locked", 8'h00, {7'h00, hd_oe});
    slave_cyc(1'b1, {2'b10, 5'h00, 2'b01, 1'b0, 3'd2}, 8'h00);
    check("lockout_clear", 8'h00, {7'h00, host_lockout});
    check("general_clear", 8'h00, general_latch);
    slave_cyc(1'b0, {3'b000, a}, 8'h00);
    check("buffer_kept", 8'(buf_model[a]), q);
    cpu.access(1'b1, a, 8'h00, 2, q, acked);
    check("unlocked_read", 8'(buf_model[a]), q);
    check("unlocked_acked", 8'h01, {7'h00, acked});
    check("drive_untouched", exp_drive, drive_latch);
    $display("Lockout test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== verif/fdh_host_cpu_model.sv ====
// Host bus master model that makes buffer accesses and ends unanswered ones by timeout.
`timescale 1ns/1ns
`default_nettype none
module fdh_host_cpu_model (
  // Clock
  input  wire logic       sys_clk,
  // Host bus
  output logic            host_sel,
  output logic            host_addr_strobe,
  output logic            host_rd,
  output logic [9:0]      host_addr,
  output logic [7:0]      host_data_lines_in,
  input  wire logic [7:0] host_data_lines_out,
  input  wire logic       host_data_lines_oe,
  input  wire logic       transfer_ack_n_out,
  input  wire logic       transfer_ack_n_oe,
  output logic            bus_error_n
);
  logic ack_line;
  // The acknowledge line is pulled up, so a floating driver reads as high.
  assign ack_line = transfer_ack_n_oe ? transfer_ack_n_out : 1'b1;
  initial begin
    host_sel = 1'b0;
    host_addr_strobe = 1'b0;
    host_rd = 1'b1;
    host_addr = 10'h000;
    host_data_lines_in = 8'h00;
    bus_error_n = 1'b1;
  end
  task automatic access(input logic rd, input logic [9:0] a, input logic [7:0] wd, input int slow,
                        output logic [7:0] rdata, output logic acked);
    int n;
    rdata = 8'h00;
    acked = 1'b0;
    n = 0;
    @(posedge sys_clk);
    host_sel <= 1'b1;
    host_addr_strobe <= 1'b1;
    host_rd <= rd;
    host_addr <= a;
    host_data_lines_in <= wd;
    while (!acked && n < 64) begin
      @(posedge sys_clk);
      n++;
      if (ack_line === 1'b0) begin
        acked = 1'b1;
        rdata = host_data_lines_oe ? host_data_lines_out : 8'hXX;
      end
    end
    if (!acked) bus_error_n <= 1'b0;
    repeat (slow) @(posedge sys_clk);
    // Released lines show the inverse so a stale value never looks valid.
    host_sel <= 1'b0;
    host_addr_strobe <= 1'b0;
    host_addr <= ~a;
    host_data_lines_in <= ~wd;
    repeat (6) @(posedge sys_clk);
    bus_error_n <= 1'b1;
  endtask
endmodule
`default_nettype wire
